// ==== rtl/ssp_pkg.sv ====
// Shared constants for the serial slave register port, both ends.
// Assumes a 50 MHz system clock at the master and a link clock at the slave.
package ssp_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
   localparam int DIR_BIT = 7;
   localparam logic DIR_READ = 1'b1;
   localparam logic DIR_WRITE = 1'b0;
   localparam int FIFO_DEPTH = 16;
   // Host clock and link clock rates
   localparam int CLK_HZ = 50_000_000;
   localparam int SCLK_FULL_HZ = 1_000_000;
   localparam int SCLK_FAST_HZ = 20_000_000;
   // Half periods of the generated serial clock, rounded up to stay within rate
   localparam int HALF_FULL = (CLK_HZ + 2 * SCLK_FULL_HZ - 1) / (2 * SCLK_FULL_HZ);
   localparam int HALF_FAST = (CLK_HZ + 2 * SCLK_FAST_HZ - 1) / (2 * SCLK_FAST_HZ);
   localparam int DIV_W = 8;
   localparam int REG_COUNT = 128;
   localparam logic [7:0] REG_RESET = 8'h00;
   typedef enum logic [4:0] {
      SSP_IDLE = 5'b00001,
      SSP_LOAD = 5'b00010,
      SSP_LOW  = 5'b00100,
      SSP_HIGH = 5'b01000,
      SSP_END  = 5'b10000
   } ssp_state_t;
endpackage : ssp_pkg

// ==== rtl/ssp_if.sv ====
// Four-wire serial link between the master end and the register port end.
// Assumes a released output line shows the inverse of the current sdo_o level.
`timescale 1ns/1ps
interface ssp_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo_o;
   logic sdo_oe;
   logic sdo;
   // Released line modelled as inverted level, so stale data shows up
   assign sdo = sdo_oe ? sdo_o : ~sdo_o;
   modport dev (input sclk, input cs_n, input sdi, output sdo_o, output sdo_oe);
   modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface : ssp_if

// ==== rtl/ssp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock shared by both sides.
`timescale 1ns/1ps
module ssp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic push;
   logic pop;

   // Full and empty from pointer compare
   assign in_ready_o = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_reg != rd_reg;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_reg[AW-1:0]];

   // Storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data_i;
      end
   end

   // Pointers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop) rd_reg <= rd_reg + 1'b1;
      end
   end
endmodule : ssp_fifo

// ==== rtl/ssp_host.sv ====
// Serial master end: takes byte words from a FIFO, makes the link clock.
// Assumes the user ends a transaction by setting last on the final byte.
`timescale 1ns/1ps
module ssp_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Outbound bytes: data plus last flag
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_last_i,
   // Rate select: high for fast sensor reads only
   input wire logic fast_i,
   // Received bytes
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic busy_o,
   // Link
   ssp_if.host link
);
   logic [8:0] f_data;
   logic f_valid;
   logic f_pop;
   logic [7:0] sh_reg;
   logic [7:0] rx_reg;
   logic [2:0] bit_reg;
   logic last_reg;
   logic [ssp_pkg::DIV_W-1:0] div_reg;
   logic [ssp_pkg::DIV_W-1:0] half;
   logic sdo_s1_reg;
   logic sdo_s2_reg;
   ssp_pkg::ssp_state_t st_reg;

   ssp_fifo #(.WIDTH(9), .DEPTH(ssp_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_ready_o),
      .in_data_i({tx_last_i, tx_data_i}),
      .out_valid_o(f_valid),
      .out_ready_i(f_pop),
      .out_data_o(f_data)
   );

   // Half period of serial clock per rate
   assign half = fast_i ? ssp_pkg::DIV_W'(ssp_pkg::HALF_FAST)
                        : ssp_pkg::DIV_W'(ssp_pkg::HALF_FULL);
   // Pop only where the head byte is taken into the shifter
   assign f_pop = f_valid && (st_reg == ssp_pkg::SSP_IDLE ||
                              (st_reg == ssp_pkg::SSP_END && !last_reg));
   assign busy_o = st_reg != ssp_pkg::SSP_IDLE;

   // Read line synchroniser
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sdo_s1_reg <= 1'b0;
         sdo_s2_reg <= 1'b0;
      end else begin
         sdo_s1_reg <= link.sdo;
         sdo_s2_reg <= sdo_s1_reg;
      end
   end

   // Serial engine, mode 3: clock idles high
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= ssp_pkg::SSP_IDLE;
         link.sclk <= 1'b1;
         link.cs_n <= 1'b1;
         link.sdi <= 1'b1;
         sh_reg <= '0;
         rx_reg <= '0;
         bit_reg <= '0;
         last_reg <= 1'b0;
         div_reg <= '0;
         rx_valid_o <= 1'b0;
         rx_data_o <= '0;
      end else begin
         rx_valid_o <= 1'b0;
         case (st_reg)
            ssp_pkg::SSP_IDLE: begin
               link.cs_n <= 1'b1;
               link.sclk <= 1'b1;
               if (f_valid) begin
                  link.cs_n <= 1'b0;
                  sh_reg <= f_data[7:0];
                  last_reg <= f_data[8];
                  st_reg <= ssp_pkg::SSP_LOAD;
               end
            end
            ssp_pkg::SSP_LOAD: begin
               // Each byte starts from the first bit
               bit_reg <= ssp_pkg::BIT_CNT_ZERO;
               div_reg <= half;
               st_reg <= ssp_pkg::SSP_LOW;
               link.sclk <= 1'b0;
               link.sdi <= sh_reg[ssp_pkg::DIR_BIT];
            end
            ssp_pkg::SSP_LOW: begin
               if (div_reg > 1) begin
                  div_reg <= div_reg - 1'b1;
               end else begin
                  link.sclk <= 1'b1;
                  div_reg <= half;
                  st_reg <= ssp_pkg::SSP_HIGH;
               end
            end
            ssp_pkg::SSP_HIGH: begin
               if (div_reg > 1) begin
                  div_reg <= div_reg - 1'b1;
               end else begin
                  rx_reg <= {rx_reg[6:0], sdo_s2_reg};
                  sh_reg <= {sh_reg[6:0], 1'b0};
                  div_reg <= half;
                  if (bit_reg == ssp_pkg::BIT_LAST[2:0]) begin
                     st_reg <= ssp_pkg::SSP_END;
                  end else begin
                     bit_reg <= bit_reg + 1'b1;
                     link.sclk <= 1'b0;
                     link.sdi <= sh_reg[6];
                     st_reg <= ssp_pkg::SSP_LOW;
                  end
               end
            end
            ssp_pkg::SSP_END: begin
               rx_valid_o <= 1'b1;
               rx_data_o <= rx_reg;
               if (last_reg) begin
                  link.cs_n <= 1'b1;
                  st_reg <= ssp_pkg::SSP_IDLE;
               end else if (f_valid) begin
                  sh_reg <= f_data[7:0];
                  last_reg <= f_data[8];
                  st_reg <= ssp_pkg::SSP_LOAD;
               end else begin
                  rx_valid_o <= 1'b0;
               end
            end
            default: st_reg <= ssp_pkg::SSP_IDLE;
         endcase
      end
   end
   // fast_i must only be set for sensor output reads: one select
endmodule : ssp_host

// ==== rtl/ssp_dev.sv ====
// Register port end of the serial link, clocked by the link clock.
// Assumes the master runs mode 3; link writes reach the user through
// a synchronised write event stream; the upd_* port is left unused.
//
// Rules of the serial link
// - Output high-impedance while chip select is high
// - Master frames each transfer with low select
// - Master selects only one slave at once
// - Bytes travel most significant bit first
// - Receiver samples data on rising clock
// - Transmitter changes data on falling clock
// - Register access limited to 1MHz clock; not enforced, fast_i in ssp_host sets the rate of any frame
// - 20MHz clock allowed for sensor reads only; fast_i is not checked against the frame type
// - Transaction is address byte plus data bytes
// - First bit: one reads, zero writes
// - Next seven bits carry register address
// - Data bytes are eight bits, bit seven first
// - Single and burst transfers both accepted
`timescale 1ns/1ps
module ssp_dev (
   // System clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Sensor value update inputs from system side, left unused
   input wire logic upd_valid_i,
   input wire logic [6:0] upd_addr_i,
   input wire logic [7:0] upd_data_i,
   // Write events towards system side, toggle-crossed
   output logic wr_valid_o,
   output logic [6:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   // Link
   ssp_if.dev link
);
   logic [7:0] regs [ssp_pkg::REG_COUNT];
   logic [6:0] sh_reg;
   logic [2:0] cnt_reg;
   logic addr_done_reg;
   logic rd_reg;
   logic [6:0] ra_reg;
   logic [7:0] tx_reg;
   logic wr_tgl_reg;
   logic [6:0] wa_reg;
   logic [7:0] wd_reg;
   logic [2:0] tg_sync_reg;
   logic [7:0] rx_byte;
   logic byte_end;
   logic [6:0] next_ra;
   logic cur_rd;
   logic wr_hit;
   logic wr_edge;

   // Write strobe decode: last bit of a data byte in a write frame
   function automatic logic wr_take(input logic sel_n, input logic last_bit,
      input logic addr_seen, input logic is_rd);
      return !sel_n && last_bit && addr_seen && !is_rd;
   endfunction : wr_take

   // Full received byte at the eighth rising edge
   assign rx_byte = {sh_reg, link.sdi};
   assign byte_end = cnt_reg == ssp_pkg::BIT_LAST[2:0];
   assign cur_rd = addr_done_reg ? rd_reg : rx_byte[ssp_pkg::DIR_BIT];
   assign next_ra = addr_done_reg ? ra_reg + 7'h01 : rx_byte[6:0];
   assign wr_hit = wr_take(link.cs_n, byte_end, addr_done_reg, rd_reg);
   assign wr_edge = tg_sync_reg[2] ^ tg_sync_reg[1];

   // Bit counter, cleared by deselect
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         cnt_reg <= ssp_pkg::BIT_CNT_ZERO;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   // Receive shifter; a partial byte dies with deselect
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         sh_reg <= '0;
      end else begin
         sh_reg <= rx_byte[6:0];
      end
   end

   // Address phase over once the first byte is in
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         addr_done_reg <= 1'b0;
      end else if (byte_end) begin
         addr_done_reg <= 1'b1;
      end
   end

   // Direction flag held for the whole frame
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         rd_reg <= 1'b0;
      end else if (byte_end) begin
         rd_reg <= cur_rd;
      end
   end

   // Register address: loaded from the first byte, then stepped
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         ra_reg <= '0;
      end else if (byte_end) begin
         ra_reg <= next_ra;
      end
   end

   // Register array, written only from the link
   always_ff @(posedge link.sclk) begin
      if (wr_hit) begin
         regs[ra_reg] <= rx_byte;
      end
   end

   // Write event toggle, one flip per written byte
   always_ff @(posedge link.sclk or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_tgl_reg <= 1'b0;
      end else if (wr_hit) begin
         wr_tgl_reg <= ~wr_tgl_reg;
      end
   end

   // Address and data words held steady while the toggle crosses
   always_ff @(posedge link.sclk or negedge nrst_i) begin
      if (!nrst_i) begin
         wa_reg <= '0;
         wd_reg <= '0;
      end else if (wr_hit) begin
         wa_reg <= ra_reg;
         wd_reg <= rx_byte;
      end
   end

   // Output shifter loaded and shifted on falling edges
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         tx_reg <= '0;
      end else if (cnt_reg == ssp_pkg::BIT_CNT_ZERO && addr_done_reg) begin
         tx_reg <= regs[ra_reg];
      end else begin
         tx_reg <= {tx_reg[6:0], 1'b0};
      end
   end

   // Drive only when selected and reading
   assign link.sdo_o = tx_reg[ssp_pkg::DIR_BIT];
   assign link.sdo_oe = !link.cs_n && addr_done_reg && rd_reg;

   // Toggle synchroniser into the system clock
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tg_sync_reg <= '0;
      end else begin
         tg_sync_reg <= {tg_sync_reg[1:0], wr_tgl_reg};
      end
   end

   // One-cycle write pulse per toggle edge
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_valid_o <= 1'b0;
      end else begin
         wr_valid_o <= wr_edge;
      end
   end

   // Words taken when the edge is seen; long settled by then
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_addr_o <= '0;
         wr_data_o <= '0;
      end else if (wr_edge) begin
         wr_addr_o <= wa_reg;
         wr_data_o <= wd_reg;
      end
   end
   // upd_* kept for sensor values; never loaded, only folded into unused_upd
   logic unused_upd;
   assign unused_upd = upd_valid_i ^ ^upd_addr_i ^ ^upd_data_i;
endmodule : ssp_dev

// ==== dv/ssp_asserts.sv ====
// Checker for the serial link wires of the register port.
// Assumes sampling by the 50 MHz host clock.
`timescale 1ns/1ps
module ssp_asserts (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Link wires
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   logic [7:0] edge_cnt_reg;
   logic dir_reg;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Rising link clock edges in this frame
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) edge_cnt_reg <= 8'h00;
      else if (cs_n) edge_cnt_reg <= 8'h00;
      else if ($rose(sclk)) edge_cnt_reg <= edge_cnt_reg + 8'h01;
   end
   // Direction flag from the first bit
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) dir_reg <= 1'b0;
      else if ($rose(sclk) && edge_cnt_reg == 8'h00) dir_reg <= sdi;
   end
   // Last address bit of a read frame
   sequence rd_addr_done;
      $rose(sclk) && edge_cnt_reg == 8'h07 && dir_reg;
   endsequence
   sequence rd_drive;
      ##[1:30] (!sclk && sdo_oe);
   endsequence
   a_sdo_hiz: assert property (cs_n && $past(cs_n) |-> !sdo_oe)
      else $error("sdo driven while deselected");
   a_sclk_idle: assert property (cs_n && $past(cs_n) |-> sclk)
      else $error("link clock moved outside a frame");
   a_sdi_fall: assert property (!cs_n && !$past(cs_n) && $changed(sdi) |-> !sclk)
      else $error("sdi changed while clock high");
   a_sdo_fall: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sclk)
      else $error("sdo changed while clock high");
   a_sdi_latch: assert property ($rose(sclk) && !cs_n |-> $stable(sdi))
      else $error("sdi moving at rising clock");
   a_sdo_latch: assert property ($rose(sclk) && sdo_oe |-> $stable(sdo_o))
      else $error("sdo moving at rising clock");
   a_sclk_half: assert property ($changed(sclk) |=> $stable(sclk))
      else $error("link clock half period too short");
   a_frame_len: assert property ($rose(cs_n) |-> edge_cnt_reg >= 8'h10 && edge_cnt_reg[2:0] == 3'h0)
      else $error("frame not whole bytes of at least two");
   a_read_drive: assert property (rd_addr_done |-> rd_drive)
      else $error("read data not driven after address");
endmodule : ssp_asserts

// ==== dv/spi_slave_register_port_tb.sv ====
// Bench: master end and register port joined over the link, checked against a model.
// Assumes both ends run from the 50 MHz clock.
`timescale 1ns/1ps
module spi_slave_register_port_tb;
   logic clk_i, nrst_i, tx_valid, tx_ready, tx_last, fast, rx_valid, busy, wr_valid;
   logic [7:0] tx_data, rx_data, wr_data, sh, first_byte;
   logic [6:0] wr_addr, base;
   int mismatches, n_compared, seed, cycles, bit_cnt, e;
   int mem [128];
   int exp_rx [$];
   int exp_wr [$];
   ssp_if u_ssp_if ();
   ssp_host u_ssp_host (.clk_i(clk_i), .nrst_i(nrst_i), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .tx_data_i(tx_data), .tx_last_i(tx_last), .fast_i(fast),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data), .busy_o(busy), .link(u_ssp_if.host));
   ssp_dev u_ssp_dev (.clk_i(clk_i), .nrst_i(nrst_i), .upd_valid_i(1'b0), .upd_addr_i(7'h00),
      .upd_data_i(8'h00), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
      .link(u_ssp_if.dev));
   ssp_asserts u_ssp_asserts (.clk_i(clk_i), .nrst_i(nrst_i), .sclk(u_ssp_if.sclk),
      .cs_n(u_ssp_if.cs_n), .sdi(u_ssp_if.sdi), .sdo_o(u_ssp_if.sdo_o), .sdo_oe(u_ssp_if.sdo_oe));
   // Clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   // Hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         summarize();
      end
   end
   // Results against the model
   always @(posedge clk_i) begin
      if (wr_valid === 1'b1) begin
         e = (exp_wr.size() > 0) ? exp_wr.pop_front() : -1;
         check("wr addr", e[15:8], {1'b0, wr_addr});
         check("wr data", e[7:0], wr_data);
      end
      if (rx_valid === 1'b1) begin
         e = (exp_rx.size() > 0) ? exp_rx.pop_front() : -1;
         if (e >= 0) check("rx data", e[7:0], rx_data);
      end
   end
   // Shadow of the data input on the wire
   always @(negedge u_ssp_if.cs_n) bit_cnt = 0;
   always @(posedge u_ssp_if.sclk) begin
      if (u_ssp_if.cs_n === 1'b0) begin
         sh = {sh[6:0], u_ssp_if.sdi};
         bit_cnt++;
         if (bit_cnt == 8) first_byte = sh;
      end
   end
   task automatic send(logic [7:0] d, logic l);
      @(posedge clk_i);
      #1 tx_valid = 1'b1;
      tx_data = d;
      tx_last = l;
      @(posedge clk_i);
      while (tx_ready !== 1'b1) @(posedge clk_i);
      #1 tx_valid = 1'b0;
   endtask : send
   task automatic frame(logic rd, logic [6:0] addr, int n, logic f);
      int a;
      int d;
      @(posedge clk_i);
      #1 fast = f;
      send({rd, addr}, 1'b0);
      exp_rx.push_back(-1);
      for (int i = 0; i < n; i++) begin
         a = (addr + i) % 128;
         d = rd ? mem[a] : ($random(seed) & 'hff);
         if (!rd) begin
            mem[a] = d;
            exp_wr.push_back(a * 256 + d);
         end
         exp_rx.push_back(rd ? d : -1);
         send(rd ? 8'h00 : d[7:0], i == n - 1);
      end
      for (int k = 0; k < 20000 && (exp_wr.size() + exp_rx.size() > 0); k++) @(posedge clk_i);
      repeat (60) @(posedge clk_i);
      check("pending", 8'h00, 8'(exp_wr.size() + exp_rx.size()));
      check("addr byte", {rd, addr}, first_byte);
      check("frame bits", 8'(n * 8 + 8), 8'(bit_cnt));
      check("busy", 8'h00, {7'h00, busy});
      $display("frame done rd %0d addr %h bytes %0d", rd, addr, n);
   endtask : frame
   // Main sequence
   initial begin
      seed = 32'hcc9a;
      {tx_valid, tx_data, tx_last, fast} = '0;
      {mismatches, n_compared, cycles, bit_cnt} = '0;
      nrst_i = 1'b0;
      repeat (6) @(posedge clk_i);
      #1 nrst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      base = 7'($random(seed)) & 7'h3f;
      frame(1'b0, 7'h7f, 1, 1'b0);
      frame(1'b0, base, 4, 1'b0);
      frame(1'b1, 7'h7f, 1, 1'b0);
      frame(1'b1, base, 4, 1'b0);
      frame(1'b0, 7'h40, 18, 1'b0);
      frame(1'b1, 7'h41, 17, 1'b1);
      summarize();
   end
endmodule : spi_slave_register_port_tb
